/* hw/spindle_pkg.sv */
// Constants and types for the spindle mode and commutation control block
// Operation
// R1 - Run mode steps the sequencer from every internal oscillator clock
// R2 - Start mode steps the sequencer only from external step-advance pulses
// R3 - Step-advance rising edge steps when reset low; high step-advance blocks other clocks; code steps on the edge only in start mode
// R4 - High-current select low scales peak winding current to one quarter
// R5 - Oscillator output forced low while oscillator is held in reset
// R6 - First oscillator clock issued immediately when oscillator leaves reset
// R7 - Outside brake, low and high gate drives both switch with PWM
// R8 - In brake, low-side drives on, high-side drives off, no PWM
// R9 - Mode decoded from reset, enable and drive-power inputs per table
// R10 - Reset high with enable low decodes as brake
// R11 - Sensor output: oscillator in preset/run/brake, position sense in start, pair compare in coast
// R12 - Preset and brake reset the sequencer, idle the oscillator, tie filter to idle
// R13 - Start resets oscillator at zero phase; run and coast let everything run
// R14 - Braking is latched from brake mode or power fail, cleared only by preset
// R15 - Active-low brake input low sets the same brake latch
// R16 - Drive-power low turns off all drivers unless brake is active
// R17 - Charge pump polarity from winding phase comparison and commutator phase
// R18 - Controller presets, starts with accelerating steps, then selects run
// R19 - Controller times sensor rise in start mode for position sensing
// R20 - Controller derives speed from sensor frequency and pole count
// R21 - Mode, power and step inputs are synchronised; step edges detected
package spindle_pkg;
    typedef enum logic [2:0] {
        MODE_PRESET,
        MODE_START,
        MODE_RUN,
        MODE_COAST,
        MODE_BRAKE
    } spin_mode_t;

    localparam int PHASES = 3;
    localparam int STEPS = 6;
    localparam logic [2:0] STEP_RESET = 3'h0;
    localparam logic [2:0] STEP_LAST = 3'h5;
    localparam logic [1:0] SCALE_FULL = 2'h3;
    localparam logic [1:0] SCALE_QUARTER = 2'h0;
    localparam int SYNC_STAGES = 2;
endpackage

/* hw/spindle_ctrl_if.sv */
// Interface carrying step requests from the mode logic to the sequencer
`timescale 1ns/1ps
interface spindle_ctrl_if;
    logic step;
    logic hold_reset;
    logic [2:0] phase;
    modport ctrl (output step, output hold_reset, input phase);
    modport seq (input step, input hold_reset, output phase);
endinterface

/* hw/shape_sequencer.sv */
// Six-step current-shape sequencer counter
`timescale 1ns/1ps
module shape_sequencer
    import spindle_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    spindle_ctrl_if.seq ctl
);
    logic [2:0] phase_ff;
    logic [2:0] nxt_phase;

    always_comb begin
        nxt_phase = phase_ff;
        if (ctl.hold_reset) begin
            nxt_phase = STEP_RESET; // R12
        end else if (ctl.step) begin
            nxt_phase = (phase_ff == STEP_LAST) ? STEP_RESET : phase_ff + 3'h1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_ff <= STEP_RESET;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    assign ctl.phase = phase_ff;

    step_wrap_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        phase_ff <= STEP_LAST) else $error("sequencer phase out of range"); // R12
endmodule

/* hw/spindle_mode_commutation_control.sv */
// Spindle mode decode, stepping source, brake latch and gate drive control
`timescale 1ns/1ps
module spindle_mode_commutation_control
    import spindle_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic reset_ctl_i,
    input wire logic enable_ctl_i,
    input wire logic drive_power_enable_i,
    input wire logic step_advance_i,
    input wire logic brake_n_i,
    input wire logic power_fail_i,
    input wire logic high_current_select_i,
    input wire logic pwm_i,
    input wire logic osc_tick_i,
    input wire logic [2:0] current_voltage_lead_i,
    input wire logic position_sense_compare_i,
    input wire logic phase_pair_compare_i,
    output logic [2:0] low_side_gate_drive_o,
    output logic [2:0] high_side_gate_drive_o,
    output logic sensor_o,
    output logic osc_out_o,
    output logic osc_reset_o,
    output logic osc_idle_o,
    output logic loop_filter_idle_o,
    output logic pump_up_o,
    output logic pump_down_o,
    output logic [1:0] current_amplitude_scale_o,
    output logic [2:0] seq_phase_o,
    output logic brake_latched_o,
    output logic [2:0] mode_o
);
    import spindle_pkg::*;

    // ==========================================================
    // Input synchronisers
    // Asynchronous pins; first stage feeds only the second
    logic [4:0] meta_ff;
    logic [4:0] sync_ff;
    logic [4:0] nxt_meta;
    logic [4:0] nxt_sync;
    logic adv_prev_ff;
    logic nxt_adv_prev;

    always_comb begin
        nxt_meta = {reset_ctl_i, enable_ctl_i, drive_power_enable_i, step_advance_i, brake_n_i};
        nxt_sync = meta_ff; // R21
        nxt_adv_prev = sync_ff[1];
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_ff <= 5'h01;
            sync_ff <= 5'h01;
            adv_prev_ff <= 1'b0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            adv_prev_ff <= nxt_adv_prev;
        end
    end

    logic rst_s, en_s, pwr_s, adv_s, brk_n_s, adv_rise;
    assign rst_s = sync_ff[4];
    assign en_s = sync_ff[3];
    assign pwr_s = sync_ff[2];
    assign adv_s = sync_ff[1];
    assign brk_n_s = sync_ff[0];
    assign adv_rise = adv_s & ~adv_prev_ff; // R21

    // Comparator and select levels also arrive unclocked from the analog side
    logic [5:0] lvl_meta_ff;
    logic [5:0] lvl_sync_ff;
    logic [5:0] nxt_lvl_meta;
    logic [5:0] nxt_lvl_sync;

    always_comb begin
        nxt_lvl_meta = {high_current_select_i, position_sense_compare_i,
                        phase_pair_compare_i, current_voltage_lead_i};
        nxt_lvl_sync = lvl_meta_ff; // R21
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lvl_meta_ff <= 6'h00;
            lvl_sync_ff <= 6'h00;
        end else begin
            lvl_meta_ff <= nxt_lvl_meta;
            lvl_sync_ff <= nxt_lvl_sync;
        end
    end

    logic hcs_s, psc_s, ppc_s;
    logic [2:0] lead_s;
    assign hcs_s = lvl_sync_ff[5];
    assign psc_s = lvl_sync_ff[4];
    assign ppc_s = lvl_sync_ff[3];
    assign lead_s = lvl_sync_ff[2:0];

    // ==========================================================
    // Mode decode
    spin_mode_t mode;
    always_comb begin
        if (rst_s && en_s) begin
            mode = MODE_PRESET; // R9
        end else if (!rst_s && en_s) begin
            mode = MODE_START; // R9
        end else if (!rst_s && pwr_s) begin
            mode = MODE_RUN; // R9
        end else if (!rst_s) begin
            mode = MODE_COAST; // R9
        end else begin
            mode = MODE_BRAKE; // R10
        end
    end

    // ==========================================================
    // Oscillator gating and step source
    // Oscillator tick arrives on this clock as a one-cycle enable
    logic osc_hold, osc_idle, seq_hold, step_req;
    always_comb begin
        osc_hold = (mode == MODE_START); // R13
        osc_idle = (mode == MODE_PRESET) || (mode == MODE_BRAKE); // R12
        seq_hold = osc_idle; // R12
        step_req = 1'b0;
        case (mode)
            MODE_START: step_req = adv_rise & ~rst_s; // R2 R3
            MODE_RUN, MODE_COAST: step_req = osc_tick_i & ~adv_s; // R1 R3
            default: step_req = 1'b0;
        endcase
    end

    // Leaving reset yields an immediate clock for phase continuity
    logic osc_out_ff, nxt_osc_out, held_ff, nxt_held;
    always_comb begin
        nxt_held = osc_hold | osc_idle;
        if (osc_hold || osc_idle) begin
            nxt_osc_out = 1'b0; // R5
        end else if (held_ff) begin
            nxt_osc_out = 1'b1; // R6
        end else if (osc_tick_i) begin
            nxt_osc_out = ~osc_out_ff;
        end else begin
            nxt_osc_out = osc_out_ff;
        end
    end

    spindle_ctrl_if ctl_bus();
    logic first_clk;
    assign first_clk = held_ff & ~osc_hold & ~osc_idle & ~adv_s; // R6
    assign ctl_bus.step = step_req | first_clk;
    assign ctl_bus.hold_reset = seq_hold;

    shape_sequencer u_seq (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .ctl(ctl_bus)
    );

    // ==========================================================
    // Brake latch
    // Set wins over preset clear
    logic brake_ff, nxt_brake;
    always_comb begin
        if (mode == MODE_BRAKE || power_fail_i || !brk_n_s) begin
            nxt_brake = 1'b1; // R14 R15
        end else if (mode == MODE_PRESET) begin
            nxt_brake = 1'b0; // R14
        end else begin
            nxt_brake = brake_ff;
        end
    end

    // ==========================================================
    // Output register
    logic [2:0] nxt_low, nxt_high, cur_phase, pump_dir;
    logic nxt_sensor, nxt_up, nxt_dn;
    assign cur_phase = ctl_bus.phase;
    always_comb begin
        // One low and one high leg per step, PWM chopping both
        nxt_low = 3'h0;
        nxt_high = 3'h0;
        if (brake_ff || nxt_brake) begin
            nxt_low = 3'h7; // R8
            nxt_high = 3'h0; // R8
        end else if (pwr_s && !osc_idle) begin
            // Never both sides of one leg, or the bridge shorts the supply
            case (cur_phase)
                3'h0: {nxt_high, nxt_low} = {3'h1, 3'h2} & {6{pwm_i}}; // R7
                3'h1: {nxt_high, nxt_low} = {3'h1, 3'h4} & {6{pwm_i}}; // R7
                3'h2: {nxt_high, nxt_low} = {3'h2, 3'h4} & {6{pwm_i}}; // R7
                3'h3: {nxt_high, nxt_low} = {3'h2, 3'h1} & {6{pwm_i}}; // R7
                3'h4: {nxt_high, nxt_low} = {3'h4, 3'h1} & {6{pwm_i}}; // R7
                3'h5: {nxt_high, nxt_low} = {3'h4, 3'h2} & {6{pwm_i}}; // R7
                default: {nxt_high, nxt_low} = 6'h00;
            endcase
        end else begin
            nxt_low = 3'h0; // R16
            nxt_high = 3'h0; // R16
        end
        case (mode)
            MODE_START: nxt_sensor = psc_s; // R11
            MODE_COAST: nxt_sensor = ppc_s; // R11
            default: nxt_sensor = nxt_osc_out; // R11
        endcase
        pump_dir = lead_s ^ {3{cur_phase[0]}};
        nxt_up = (mode == MODE_RUN) && (^pump_dir); // R17
        nxt_dn = (mode == MODE_RUN) && !(^pump_dir); // R17
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            osc_out_ff <= 1'b0;
            held_ff <= 1'b1;
            brake_ff <= 1'b0;
            low_side_gate_drive_o <= 3'h0;
            high_side_gate_drive_o <= 3'h0;
            sensor_o <= 1'b0;
            osc_out_o <= 1'b0;
            osc_reset_o <= 1'b0;
            osc_idle_o <= 1'b1;
            loop_filter_idle_o <= 1'b1;
            pump_up_o <= 1'b0;
            pump_down_o <= 1'b0;
            current_amplitude_scale_o <= SCALE_QUARTER;
            seq_phase_o <= STEP_RESET;
            brake_latched_o <= 1'b0;
            mode_o <= 3'h0;
        end else begin
            osc_out_ff <= nxt_osc_out;
            held_ff <= nxt_held;
            brake_ff <= nxt_brake;
            low_side_gate_drive_o <= nxt_low;
            high_side_gate_drive_o <= nxt_high;
            sensor_o <= nxt_sensor;
            osc_out_o <= nxt_osc_out;
            osc_reset_o <= osc_hold;
            osc_idle_o <= osc_idle;
            loop_filter_idle_o <= (mode != MODE_RUN) && (mode != MODE_COAST); // R12 R13
            pump_up_o <= nxt_up;
            pump_down_o <= nxt_dn;
            current_amplitude_scale_o <= hcs_s ? SCALE_FULL
                                                               : SCALE_QUARTER; // R4
            seq_phase_o <= cur_phase;
            brake_latched_o <= nxt_brake;
            mode_o <= mode;
        end
    end

    // ==========================================================
    // Checks
    brake_drive_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        brake_ff |=> (low_side_gate_drive_o == 3'h7 && high_side_gate_drive_o == 3'h0))
        else $error("brake drive wrong"); // R8
    brake_hold_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        brake_ff && mode != MODE_PRESET |=> brake_ff) else $error("brake latch lost"); // R14
    brake_pin_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !brk_n_s |=> brake_ff) else $error("brake pin ignored"); // R15
    osc_low_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        osc_hold |=> !osc_out_o) else $error("osc not low in reset"); // R5
    osc_first_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        $fell(osc_hold) && !osc_idle |=> osc_out_o) else $error("no first clock"); // R6
    adv_block_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        adv_s && mode != MODE_START |-> !ctl_bus.step) else $error("step while advance high"); // R3
    start_src_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        mode == MODE_START && !adv_rise |-> !ctl_bus.step) else $error("start step source"); // R2
    power_off_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !pwr_s && !brake_ff && !nxt_brake |=>
        (high_side_gate_drive_o | low_side_gate_drive_o) == 3'h0)
        else $error("drive while power off"); // R16
    sensor_sel_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        mode == MODE_COAST |=> sensor_o == $past(ppc_s))
        else $error("sensor mux wrong"); // R11
endmodule

/* bench/host_model.sv */
// Host-side model driving the spindle mode and step-advance pins
`timescale 1ns/1ps
module host_model (
    input wire logic sys_clk_i,
    output logic reset_ctl_o,
    output logic enable_ctl_o,
    output logic drive_power_enable_o,
    output logic step_advance_o
);
    initial begin
        reset_ctl_o = 1'b0;
        enable_ctl_o = 1'b0;
        drive_power_enable_o = 1'b0;
        step_advance_o = 1'b0;
    end
    // ==========================================
    // Mode select, held until outputs settle
    task automatic set_mode(input logic r, input logic e, input logic p);
        @(negedge sys_clk_i);
        reset_ctl_o = r;
        enable_ctl_o = e;
        drive_power_enable_o = p;
        repeat (6) @(negedge sys_clk_i);
    endtask
    // Low time kept above the synchroniser depth so no edge is lost
    task automatic pulse_step();
        @(negedge sys_clk_i);
        step_advance_o = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        step_advance_o = 1'b0;
        repeat (5) @(negedge sys_clk_i);
    endtask
endmodule

/* bench/spindle_mode_commutation_control_tb.sv */
// Self-checking bench for the spindle mode and commutation control block
`timescale 1ns/1ps
module spindle_mode_commutation_control_tb;
    import spindle_pkg::*;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic brake_n = 1'b1, power_fail = 1'b0, hcs = 1'b1, pwm = 1'b0, tick = 1'b0;
    logic psc = 1'b0, ppc = 1'b0;
    logic [2:0] lead = 3'h0;
    logic rst_ctl, en_ctl, dpwr, adv;
    logic [2:0] low_drv, high_drv, phase, mode;
    logic sensor, osc_out, osc_rst, osc_idle, lf_idle, pump_up, pump_dn, latched;
    logic [1:0] scale;
    int n_fail = 0;
    int n_compared = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    host_model host_u (.sys_clk_i(sys_clk_i), .reset_ctl_o(rst_ctl), .enable_ctl_o(en_ctl),
        .drive_power_enable_o(dpwr), .step_advance_o(adv));
    spindle_mode_commutation_control dut_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .reset_ctl_i(rst_ctl), .enable_ctl_i(en_ctl), .drive_power_enable_i(dpwr),
        .step_advance_i(adv), .brake_n_i(brake_n), .power_fail_i(power_fail),
        .high_current_select_i(hcs), .pwm_i(pwm), .osc_tick_i(tick),
        .current_voltage_lead_i(lead), .position_sense_compare_i(psc),
        .phase_pair_compare_i(ppc), .low_side_gate_drive_o(low_drv),
        .high_side_gate_drive_o(high_drv), .sensor_o(sensor), .osc_out_o(osc_out),
        .osc_reset_o(osc_rst), .osc_idle_o(osc_idle), .loop_filter_idle_o(lf_idle),
        .pump_up_o(pump_up), .pump_down_o(pump_dn), .current_amplitude_scale_o(scale),
        .seq_phase_o(phase), .brake_latched_o(latched), .mode_o(mode));
    // ==========================================
    // Checking and reporting
    task automatic chk(input string nm, input logic [2:0] exp, input logic [2:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected %s expected %0h seen %0h", nm, exp, got);
            n_fail++;
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", n_fail, n_compared);
        if (n_fail == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (6) @(negedge sys_clk_i);
    endtask
    // One-cycle oscillator tick, launched off the sampling edge
    task automatic osc_pulse();
        @(negedge sys_clk_i);
        tick = 1'b1;
        @(negedge sys_clk_i);
        tick = 1'b0;
        settle();
    endtask
    // Whole run is about 140 cycles; this only cuts a hang
    initial begin
        #100us;
        n_fail++;
        final_report();
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (3) @(negedge sys_clk_i);
        arst_n_i = 1'b1;
        settle();
        chk("mode", 3'h3, mode);
        chk("low_drv", 3'h0, low_drv);
        psc = 1'b1;
        host_u.set_mode(1'b1, 1'b1, 1'b0);
        chk("mode", 3'h0, mode);
        chk("phase", 3'h0, phase);
        chk("osc_idle", 3'h1, {2'h0, osc_idle});
        chk("lf_idle", 3'h1, {2'h0, lf_idle});
        chk("sensor", 3'h0, {2'h0, sensor});
        host_u.set_mode(1'b0, 1'b1, 1'b0);
        settle();
        chk("mode", 3'h1, mode);
        chk("osc_rst", 3'h1, {2'h0, osc_rst});
        chk("osc_out", 3'h0, {2'h0, osc_out});
        chk("sensor", 3'h1, {2'h0, sensor});
        host_u.pulse_step();
        chk("phase", 3'h1, phase);
        osc_pulse();
        chk("phase", 3'h1, phase);
        psc = 1'b0;
        host_u.set_mode(1'b0, 1'b1, 1'b1);
        chk("sensor", 3'h0, {2'h0, sensor});
        psc = 1'b1;
        settle();
        chk("mode", 3'h1, mode);
        chk("sensor", 3'h1, {2'h0, sensor});
        host_u.set_mode(1'b0, 1'b0, 1'b1);
        chk("mode", 3'h2, mode);
        chk("phase", 3'h2, phase);
        chk("sensor", 3'h1, {2'h0, sensor});
        osc_pulse();
        chk("phase", 3'h3, phase);
        chk("sensor", 3'h0, {2'h0, sensor});
        chk("high_drv", 3'h0, high_drv | low_drv);
        pwm = 1'b1;
        hcs = 1'b0;
        settle();
        chk("pwm_on", 3'h1, {2'h0, |(high_drv | low_drv)});
        chk("overlap", 3'h0, high_drv & low_drv);
        chk("scale", {1'b0, SCALE_QUARTER}, {1'b0, scale});
        chk("pump_up", 3'h1, {2'h0, pump_up});
        chk("pump_dn", 3'h0, {2'h0, pump_dn});
        lead = 3'h1;
        settle();
        chk("pump_up", 3'h0, {2'h0, pump_up});
        chk("pump_dn", 3'h1, {2'h0, pump_dn});
        hcs = 1'b1;
        ppc = 1'b1;
        host_u.set_mode(1'b0, 1'b0, 1'b0);
        chk("scale", {1'b0, SCALE_FULL}, {1'b0, scale});
        chk("mode", 3'h3, mode);
        chk("sensor", 3'h1, {2'h0, sensor});
        chk("drives", 3'h0, high_drv | low_drv);
        host_u.set_mode(1'b1, 1'b0, 1'b0);
        chk("mode", 3'h4, mode);
        chk("low_drv", 3'h7, low_drv);
        chk("high_drv", 3'h0, high_drv);
        host_u.set_mode(1'b0, 1'b1, 1'b0);
        chk("latched", 3'h1, {2'h0, latched});
        host_u.set_mode(1'b1, 1'b1, 1'b0);
        chk("latched", 3'h0, {2'h0, latched});
        brake_n = 1'b0;
        settle();
        chk("latched", 3'h1, {2'h0, latched});
        brake_n = 1'b1;
        settle();
        host_u.set_mode(1'b0, 1'b1, 1'b0);
        chk("latched", 3'h0, {2'h0, latched});
        power_fail = 1'b1;
        @(negedge sys_clk_i);
        power_fail = 1'b0;
        settle();
        chk("latched", 3'h1, {2'h0, latched});
        final_report();
    end
endmodule
